// *** rtl/ppcu_cfg.svh ***
`ifndef PPCU_CFG_SVH
`define PPCU_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PPCU_OFS_CTRL 8'h00
`define PPCU_OFS_BARO 8'h04
`define PPCU_OFS_STATUS 8'h08
`define PPCU_OFS_SETPT 8'h10
`define PPCU_OFS_VMAP 8'h40

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PPCU_CTRL_PROMPT_LSB 0
`define PPCU_CTRL_ADDR_LSB 8
`define PPCU_CTRL_ABS_BIT 16

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PPCU_RST_PROMPT 8'h3E
`define PPCU_RST_ADDR 8'h31
`define PPCU_RST_ABS 1'b0
`define PPCU_RST_BARO 16'h0000
`define PPCU_RST_SETPT 16'h0000
`define PPCU_RST_VMAP 12'h000

// ----------------------------------------------------------------
// characters and command codes
// ----------------------------------------------------------------
`define PPCU_CHR_CR 8'h0D
`define PPCU_DEF_ADDR 8'h31
`define PPCU_CHR_DIG_LO 8'h31
`define PPCU_CHR_DIG_HI 8'h39
`define PPCU_CHR_LET_LO 8'h55
`define PPCU_CHR_LET_HI 8'h59
`define PPCU_MN_POS_HIGH 16'h5048
`define PPCU_MN_POS_MED 16'h504D
`define PPCU_MN_POS_LOW 16'h504C
`define PPCU_MN_NEG_HIGH 16'h4E48
`define PPCU_MN_NEG_MED 16'h4E4D
`define PPCU_MN_NEG_LOW 16'h4E4C
`define PPCU_MN_REINIT 16'h4943
`define PPCU_MN_ZERO 16'h5A4F

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define PPCU_RESP_OKAY 2'h0
`define PPCU_RESP_SLVERR 2'h2

`endif

// *** rtl/ppcu_pkg.sv ***
package ppcu_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_PROMPT = 3'b100
  } ppcu_state_t;

  typedef struct packed {
    logic ok;
    logic has_addr;
    logic [7:0] addr;
    logic [15:0] mnem;
  } ppcu_cmd_t;

  typedef struct packed {
    logic en;
    logic [5:0] idx;
    logic [31:0] data;
    logic [3:0] strb;
  } ppcu_wr_t;

endpackage : ppcu_pkg

// *** rtl/ppcu_linedec.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ppcu_cfg.svh"

module ppcu_linedec (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic take_i,
  input wire logic [7:0] data_i,
  output var logic done_o,
  output var ppcu_pkg::ppcu_cmd_t cmd_o
);
  import ppcu_pkg::*;

  logic [23:0] chars_ff;
  logic [2:0] cnt_ff;
  logic done_ff;
  ppcu_cmd_t cmd_ff;
  ppcu_cmd_t nxt_cmd;

  wire cr_take = take_i && (data_i == `PPCU_CHR_CR);
  wire [2:0] nxt_cnt = (cnt_ff == 3'h4) ? cnt_ff : cnt_ff + 3'h1;

  // two characters: bare command; three: address then command
  assign nxt_cmd.ok = (cnt_ff == 3'h2) || (cnt_ff == 3'h3);
  assign nxt_cmd.has_addr = cnt_ff == 3'h3;
  assign nxt_cmd.addr = chars_ff[23:16];
  assign nxt_cmd.mnem = chars_ff[15:0];

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      chars_ff <= 24'h000000;
      cnt_ff <= 3'h0;
      done_ff <= 1'b0;
      cmd_ff <= '0;
    end
    else
    begin
      done_ff <= cr_take; // RL15
      if (cr_take)
      begin
        cnt_ff <= 3'h0;
        cmd_ff <= nxt_cmd; // RL15
      end
      else if (take_i)
      begin
        chars_ff <= {chars_ff[15:0], data_i};
        cnt_ff <= nxt_cnt;
      end
    end
  end

  assign done_o = done_ff;
  assign cmd_o = cmd_ff;

  chk_cr_only: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL15
    done_o |-> $past(take_i) && $past(data_i) == `PPCU_CHR_CR)
    else $error("command decoded without carriage return");

endmodule : ppcu_linedec

`default_nettype wire

// *** rtl/ppcu_axil.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ppcu_cfg.svh"

module ppcu_axil (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output var logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output var logic wready_o,
  output var logic [1:0] bresp_o,
  output var logic bvalid_o,
  input wire logic bready_i,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output var logic arready_o,
  output var logic [31:0] rdata_o,
  output var logic [1:0] rresp_o,
  output var logic rvalid_o,
  input wire logic rready_i,
  output var ppcu_pkg::ppcu_wr_t wr_o,
  output var logic [7:0] rd_addr_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_err_i,
  input wire logic wr_err_i
);
  import ppcu_pkg::*;

  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;

  wire aw_take = awvalid_i && awready_ff;
  wire w_take = wvalid_i && wready_ff;
  wire do_wr = !awready_ff && !wready_ff && !bvalid_ff;
  wire ar_take = arvalid_i && arready_ff;

  // ----------------------------------------------------------------
  // write channels, address and data in either order
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bresp_ff <= `PPCU_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        awaddr_ff <= awaddr_i;
        awready_ff <= 1'b0;
      end
      else if (do_wr)
        awready_ff <= 1'b1;
      if (w_take)
      begin
        wdata_ff <= wdata_i;
        wstrb_ff <= wstrb_i;
        wready_ff <= 1'b0;
      end
      else if (do_wr)
        wready_ff <= 1'b1;
      if (do_wr)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_err_i ? `PPCU_RESP_SLVERR : `PPCU_RESP_OKAY;
      end
      else if (bready_i)
        bvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read channel, data sampled when the address is taken
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `PPCU_RESP_OKAY;
    end
    else if (ar_take)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_data_i;
      rresp_ff <= rd_err_i ? `PPCU_RESP_SLVERR : `PPCU_RESP_OKAY;
    end
    else if (rvalid_ff && rready_i)
    begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  assign wr_o = '{en: do_wr, idx: awaddr_ff[7:2], data: wdata_ff, strb: wstrb_ff};
  assign rd_addr_o = araddr_i;
  assign awready_o = awready_ff;
  assign wready_o = wready_ff;
  assign bvalid_o = bvalid_ff;
  assign bresp_o = bresp_ff;
  assign arready_o = arready_ff;
  assign rvalid_o = rvalid_ff;
  assign rdata_o = rdata_ff;
  assign rresp_o = rresp_ff;

  chk_bresp_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
    else $error("write response dropped before taken");

endmodule : ppcu_axil

`default_nettype wire

// *** rtl/ppcu_top.sv ***
// Contract
// RL1 - optional address: digits 1-9 or U to Y
// RL2 - no address means calibrator address one
// RL3 - prompt sent after every finished command; code sends none for an unknown code or bad address
// RL4 - prompt programmable, defaults to greater-than
// RL5 - positive high: load setpoint and valve map
// RL6 - positive medium: load setpoint and valve map
// RL7 - positive low: load setpoint and valve map
// RL8 - negative high: load setpoint and valve map
// RL9 - negative medium: load setpoint and valve map
// RL10 - negative low: load setpoint and valve map
// RL11 - negative magnitudes go to reference-minus output
// RL12 - reinit restores power-up state and valve map
// RL13 - after reinit no pressure output commanded
// RL14 - zero targets zero or barometric, zero map
// RL15 - decoding starts only after carriage return
// RL16 - foreign address ignored without any prompt
`timescale 1ns/1ps
`default_nettype none
`include "ppcu_cfg.svh"

module ppcu_top #(
  parameter int SP_W = 16,
  parameter int VALVES = 12
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  input wire logic [7:0] AXI_AWADDR_I,
  input wire logic AXI_AWVALID_I,
  output var logic AXI_AWREADY_O,
  input wire logic [31:0] AXI_WDATA_I,
  input wire logic [3:0] AXI_WSTRB_I,
  input wire logic AXI_WVALID_I,
  output var logic AXI_WREADY_O,
  output var logic [1:0] AXI_BRESP_O,
  output var logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  input wire logic [7:0] AXI_ARADDR_I,
  input wire logic AXI_ARVALID_I,
  output var logic AXI_ARREADY_O,
  output var logic [31:0] AXI_RDATA_O,
  output var logic [1:0] AXI_RRESP_O,
  output var logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I,
  input wire logic [7:0] CMD_DATA_I,
  input wire logic CMD_VALID_I,
  output var logic CMD_READY_O,
  output var logic [7:0] PROMPT_DATA_O,
  output var logic PROMPT_VALID_O,
  input wire logic PROMPT_READY_I,
  output var logic [VALVES-1:0] SOLENOID_O,
  output var logic [SP_W-1:0] TARGET_O,
  output var logic NORMAL_EN_O,
  output var logic REFMINUS_EN_O
);
  import ppcu_pkg::*;

  localparam int NSP = 6;
  localparam int NMAP = 8;
  localparam logic [5:0] IDX_CTRL = 6'(`PPCU_OFS_CTRL >> 2);
  localparam logic [5:0] IDX_BARO = 6'(`PPCU_OFS_BARO >> 2);
  localparam logic [5:0] IDX_STAT = 6'(`PPCU_OFS_STATUS >> 2);
  localparam logic [5:0] IDX_SETPT = 6'(`PPCU_OFS_SETPT >> 2);
  localparam logic [5:0] IDX_VMAP = 6'(`PPCU_OFS_VMAP >> 2);
  localparam logic [2:0] SEL_NEG_LO = 3'h3;
  localparam logic [2:0] SEL_REINIT = 3'h6;
  localparam logic [2:0] SEL_ZERO = 3'h7;
  localparam logic [15:0] MN_CODE [NMAP] = '{`PPCU_MN_POS_HIGH, `PPCU_MN_POS_MED,
    `PPCU_MN_POS_LOW, `PPCU_MN_NEG_HIGH, `PPCU_MN_NEG_MED, `PPCU_MN_NEG_LOW,
    `PPCU_MN_REINIT, `PPCU_MN_ZERO};

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
    input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return res;
  endfunction : merge

  ppcu_wr_t wr;
  ppcu_cmd_t cmd;
  logic cmd_done;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err, wr_err;
  ppcu_state_t st_ff, nxt_st;
  logic ready_ff, pvalid_ff, abs_ff, normal_ff, refm_ff;
  logic [7:0] pdata_ff, prompt_ff, own_addr_ff;
  logic [SP_W-1:0] baro_ff, target_ff;
  logic [SP_W-1:0] setpt_ff [NSP];
  logic [VALVES-1:0] vmap_ff [NMAP];
  logic [VALVES-1:0] solen_ff;
  logic [NMAP-1:0] mn_hit;
  logic [2:0] sel;

  // ----------------------------------------------------------------
  // register bus and command line
  // ----------------------------------------------------------------
  wire cmd_take = CMD_VALID_I && ready_ff;
  wire cr_take = cmd_take && (CMD_DATA_I == `PPCU_CHR_CR);

  ppcu_axil u_axil (
    .clk_i(CORE_CLK_I), .rst_b_i(RST_B_I),
    .awaddr_i(AXI_AWADDR_I), .awvalid_i(AXI_AWVALID_I), .awready_o(AXI_AWREADY_O),
    .wdata_i(AXI_WDATA_I), .wstrb_i(AXI_WSTRB_I), .wvalid_i(AXI_WVALID_I),
    .wready_o(AXI_WREADY_O), .bresp_o(AXI_BRESP_O), .bvalid_o(AXI_BVALID_O),
    .bready_i(AXI_BREADY_I), .araddr_i(AXI_ARADDR_I), .arvalid_i(AXI_ARVALID_I),
    .arready_o(AXI_ARREADY_O), .rdata_o(AXI_RDATA_O), .rresp_o(AXI_RRESP_O),
    .rvalid_o(AXI_RVALID_O), .rready_i(AXI_RREADY_I), .wr_o(wr), .rd_addr_o(rd_addr),
    .rd_data_i(rd_data), .rd_err_i(rd_err), .wr_err_i(wr_err)
  );

  ppcu_linedec u_dec (
    .clk_i(CORE_CLK_I), .rst_b_i(RST_B_I), .take_i(cmd_take),
    .data_i(CMD_DATA_I), .done_o(cmd_done), .cmd_o(cmd)
  );

  // ----------------------------------------------------------------
  // command qualification
  // ----------------------------------------------------------------
  wire dig_ok = (cmd.addr >= `PPCU_CHR_DIG_LO) && (cmd.addr <= `PPCU_CHR_DIG_HI);
  wire let_ok = (cmd.addr >= `PPCU_CHR_LET_LO) && (cmd.addr <= `PPCU_CHR_LET_HI);
  wire addr_ok = !cmd.has_addr || dig_ok || let_ok; // RL1
  wire [7:0] eff_addr = cmd.has_addr ? cmd.addr : `PPCU_DEF_ADDR; // RL2
  wire for_me = eff_addr == own_addr_ff; // RL16

  genvar g;
  generate
    for (g = 0; g < NMAP; g++)
    begin : g_mn
      assign mn_hit[g] = cmd.mnem == MN_CODE[g];
    end
  endgenerate

  always_comb
  begin
    sel = 3'h0;
    for (int i = 0; i < NMAP; i++)
    begin
      if (mn_hit[i])
        sel = 3'(i);
    end
  end

  wire known = |mn_hit;
  wire accept = cmd_done && cmd.ok && addr_ok && for_me && known; // RL1 RL15 RL16
  wire is_sp = sel < 3'(NSP);
  wire is_neg = is_sp && (sel >= SEL_NEG_LO);
  wire [SP_W-1:0] sel_sp = is_sp ? setpt_ff[sel] : '0;
  wire [VALVES-1:0] sel_map = vmap_ff[sel];
  wire [SP_W-1:0] zero_tgt = abs_ff ? baro_ff : '0; // RL14

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: if (accept) nxt_st = ST_EXEC;
      ST_EXEC: nxt_st = ST_PROMPT;
      ST_PROMPT: if (PROMPT_READY_I) nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end

  wire exec = st_ff == ST_EXEC;

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      st_ff <= ST_IDLE;
      ready_ff <= 1'b1;
      pvalid_ff <= 1'b0;
      pdata_ff <= `PPCU_RST_PROMPT;
    end
    else
    begin
      st_ff <= nxt_st;
      ready_ff <= (nxt_st == ST_IDLE) && !cr_take; // RL15
      if (exec)
      begin
        pvalid_ff <= 1'b1; // RL3
        pdata_ff <= prompt_ff; // RL4
      end
      else if (PROMPT_READY_I)
        pvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pressure target and valve outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      solen_ff <= `PPCU_RST_VMAP;
      target_ff <= '0;
      normal_ff <= 1'b0;
      refm_ff <= 1'b0;
    end
    else if (exec)
    begin
      solen_ff <= sel_map; // RL5 RL6 RL7 RL8 RL9 RL10 RL12 RL14
      if (is_sp)
      begin
        target_ff <= sel_sp; // RL5 RL6 RL7 RL8 RL9 RL10
        normal_ff <= !is_neg;
        refm_ff <= is_neg; // RL11
      end
      else if (sel == SEL_REINIT)
      begin
        target_ff <= '0; // RL12
        normal_ff <= 1'b0; // RL13
        refm_ff <= 1'b0; // RL13
      end
      else
      begin
        target_ff <= zero_tgt; // RL14
        normal_ff <= 1'b1;
        refm_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  wire wr_ctrl = wr.en && (wr.idx == IDX_CTRL);
  wire wr_baro = wr.en && (wr.idx == IDX_BARO);
  wire [31:0] ctrl_rd = {15'h0000, abs_ff, own_addr_ff, prompt_ff};
  wire [31:0] ctrl_new = merge(ctrl_rd, wr.data, wr.strb);
  wire [31:0] baro_new = merge(32'(baro_ff), wr.data, wr.strb);

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      prompt_ff <= `PPCU_RST_PROMPT; // RL4
      own_addr_ff <= `PPCU_RST_ADDR;
      abs_ff <= `PPCU_RST_ABS;
      baro_ff <= `PPCU_RST_BARO;
    end
    else
    begin
      if (wr_ctrl)
      begin
        prompt_ff <= ctrl_new[`PPCU_CTRL_PROMPT_LSB +: 8]; // RL4
        own_addr_ff <= ctrl_new[`PPCU_CTRL_ADDR_LSB +: 8];
        abs_ff <= ctrl_new[`PPCU_CTRL_ABS_BIT];
      end
      if (wr_baro)
        baro_ff <= baro_new[SP_W-1:0];
    end
  end

  generate
    for (g = 0; g < NMAP; g++)
    begin : g_store
      wire map_hit = wr.en && (wr.idx == IDX_VMAP + 6'(g));
      wire [31:0] map_new = merge(32'(vmap_ff[g]), wr.data, wr.strb);
      always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
      begin
        if (!RST_B_I)
          vmap_ff[g] <= `PPCU_RST_VMAP;
        else if (map_hit)
          vmap_ff[g] <= map_new[VALVES-1:0];
      end
      if (g < NSP)
      begin : g_sp
        wire sp_hit = wr.en && (wr.idx == IDX_SETPT + 6'(g));
        wire [31:0] sp_new = merge(32'(setpt_ff[g]), wr.data, wr.strb);
        always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
        begin
          if (!RST_B_I)
            setpt_ff[g] <= `PPCU_RST_SETPT;
          else if (sp_hit)
            setpt_ff[g] <= sp_new[SP_W-1:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  wire [5:0] rd_idx = rd_addr[7:2];
  wire [5:0] sp_off = rd_idx - IDX_SETPT;
  wire [5:0] map_off = rd_idx - IDX_VMAP;
  wire rd_sp = (rd_idx >= IDX_SETPT) && (sp_off < 6'(NSP));
  wire rd_map = (rd_idx >= IDX_VMAP) && (map_off < 6'(NMAP));
  wire [31:0] stat_rd = 32'({st_ff != ST_IDLE, refm_ff, normal_ff, target_ff});
  wire wr_sp = (wr.idx >= IDX_SETPT) && (wr.idx - IDX_SETPT < 6'(NSP));
  wire wr_map = (wr.idx >= IDX_VMAP) && (wr.idx - IDX_VMAP < 6'(NMAP));
  assign wr_err = !((wr.idx == IDX_CTRL) || (wr.idx == IDX_BARO) || wr_sp || wr_map);

  always_comb
  begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    if (rd_idx == IDX_CTRL)
      rd_data = ctrl_rd;
    else if (rd_idx == IDX_BARO)
      rd_data = 32'(baro_ff);
    else if (rd_idx == IDX_STAT)
      rd_data = stat_rd;
    else if (rd_sp)
      rd_data = 32'(setpt_ff[sp_off[2:0]]);
    else if (rd_map)
      rd_data = 32'(vmap_ff[map_off[2:0]]);
    else
      rd_err = 1'b1;
  end

  assign CMD_READY_O = ready_ff;
  assign PROMPT_VALID_O = pvalid_ff;
  assign PROMPT_DATA_O = pdata_ff;
  assign SOLENOID_O = solen_ff;
  assign TARGET_O = target_ff;
  assign NORMAL_EN_O = normal_ff;
  assign REFMINUS_EN_O = refm_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RST_B_I);

  chk_addr_valid: assert property (cmd_done && !addr_ok |=> st_ff == ST_IDLE && !PROMPT_VALID_O) // RL1
    else $error("invalid address character executed");
  chk_default_addr: assert property (cmd_done && cmd.ok && !cmd.has_addr && known // RL2
    && own_addr_ff == `PPCU_DEF_ADDR && st_ff == ST_IDLE |=> st_ff == ST_EXEC)
    else $error("unaddressed command not taken by address one");
  chk_prompt_after: assert property (accept && st_ff == ST_IDLE |-> ##2 PROMPT_VALID_O) // RL3
    else $error("no prompt two cycles after accepted command");
  chk_prompt_char: assert property (exec |=> PROMPT_DATA_O == $past(prompt_ff)) // RL4
    else $error("prompt character differs from programmed one");
  chk_prompt_hold: assert property (PROMPT_VALID_O && !PROMPT_READY_I // RL3
    |=> PROMPT_VALID_O && $stable(PROMPT_DATA_O))
    else $error("prompt dropped before taken");
  chk_pos_load: assert property (exec && is_sp && !is_neg |=> TARGET_O == $past(sel_sp) // RL5
    && NORMAL_EN_O && !REFMINUS_EN_O && SOLENOID_O == $past(sel_map))
    else $error("positive setpoint not applied");
  chk_neg_route: assert property (exec && is_neg |=> TARGET_O == $past(sel_sp) // RL11
    && REFMINUS_EN_O && !NORMAL_EN_O && SOLENOID_O == $past(sel_map))
    else $error("negative setpoint not routed to reference minus");
  chk_reinit_off: assert property (exec && sel == SEL_REINIT |=> !NORMAL_EN_O // RL12
    && !REFMINUS_EN_O && SOLENOID_O == $past(vmap_ff[6]))
    else $error("reinit did not restore power-up outputs");
  chk_reinit_hold: assert property (!NORMAL_EN_O && !REFMINUS_EN_O && !exec // RL13
    |=> !NORMAL_EN_O && !REFMINUS_EN_O)
    else $error("pressure output enabled without a setting command");
  chk_zero_target: assert property (exec && sel == SEL_ZERO |=> TARGET_O == $past(zero_tgt) // RL14
    && NORMAL_EN_O && SOLENOID_O == $past(vmap_ff[7]))
    else $error("zero command target or valves wrong");
  chk_foreign_quiet: assert property (cmd_done && !for_me |=> !PROMPT_VALID_O [*2]) // RL16
    else $error("prompt sent for foreign address");
  chk_busy_block: assert property (st_ff != ST_IDLE |-> !CMD_READY_O) // RL15
    else $error("link accepting characters while busy");

  cov_neg_cmd: cover property (exec && is_neg);
  cov_reinit_cmd: cover property (exec && sel == SEL_REINIT);
  cov_foreign_cmd: cover property (cmd_done && cmd.ok && !for_me);
  cov_prompt_stall: cover property (PROMPT_VALID_O && !PROMPT_READY_I ##1 PROMPT_READY_I);

endmodule : ppcu_top

`default_nettype wire

// *** sim/ppcu_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppcu_host (
  input wire logic clk_i,
  input wire logic ready_i,
  input wire logic [7:0] prompt_i,
  input wire logic pvalid_i,
  input wire logic slow_i,
  output var logic [7:0] data_o,
  output var logic valid_o,
  output var logic pready_o
);
  int n_prompt = 0;
  logic [7:0] last_prompt = 8'h00;
  logic [7:0] lfsr = 8'hA5;
  initial
  begin
    data_o = 8'hFF;
    valid_o = 1'b0;
    pready_o = 1'b0;
  end
  // one line: address text and letters, closed by carriage return
  task automatic send(input string s);
    for (int i = 0; i <= s.len(); i++)
    begin
      @(posedge clk_i);
      data_o <= (i == s.len()) ? 8'h0D : 8'(s[i]);
      valid_o <= 1'b1;
      do @(posedge clk_i); while (ready_i !== 1'b1);
      valid_o <= 1'b0;
      data_o <= ~data_o;
    end
  endtask : send
  // prompt sink, stalls at random when slow
  always @(posedge clk_i)
  begin
    lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    pready_o <= !slow_i || lfsr[0];
    if (pvalid_i && pready_o)
    begin
      n_prompt++;
      last_prompt <= prompt_i;
    end
  end
endmodule : ppcu_host
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, cmd_data, prompt_data;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, slow = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'd93803;
  logic awready, wready, bvalid, arready, rvalid, cmd_valid, cmd_ready, prompt_valid, prompt_ready, nen, ren;
  logic [1:0] bresp, rresp;
  logic [11:0] sol, e_sol = 12'h000;
  logic [15:0] tgt, e_tgt = 16'h0000, baro = 16'h0000;
  logic [15:0] sp [6];
  logic [11:0] mp [8];
  logic e_nen = 1'b0, e_ren = 1'b0, absf = 1'b0;
  logic [7:0] own = 8'h31, pch = 8'h3E;
  int err_total = 0, n_checks = 0, n_exp = 0;
  string codes [8] = '{"PH", "PM", "PL", "NH", "NM", "NL", "IC", "ZO"};
  string addrs [5] = '{"", "1", "7", "Z", "U"};
  ppcu_top #(.SP_W(16), .VALVES(12)) dut_u (.CORE_CLK_I(clk), .RST_B_I(rst_b),
    .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid), .AXI_AWREADY_O(awready), .AXI_WDATA_I(wdata),
    .AXI_WSTRB_I(4'hF), .AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready), .AXI_BRESP_O(bresp),
    .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready), .AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid),
    .AXI_ARREADY_O(arready), .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid),
    .AXI_RREADY_I(rready), .CMD_DATA_I(cmd_data), .CMD_VALID_I(cmd_valid), .CMD_READY_O(cmd_ready),
    .PROMPT_DATA_O(prompt_data), .PROMPT_VALID_O(prompt_valid), .PROMPT_READY_I(prompt_ready),
    .SOLENOID_O(sol), .TARGET_O(tgt), .NORMAL_EN_O(nen), .REFMINUS_EN_O(ren));
  ppcu_host host_u (.clk_i(clk), .ready_i(cmd_ready), .prompt_i(prompt_data), .pvalid_i(prompt_valid),
    .slow_i(slow), .data_o(cmd_data), .valid_o(cmd_valid), .pready_o(prompt_ready));
  initial forever #20 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic void expect_cmd(input int k);
    e_sol = mp[k];
    e_tgt = (k < 6) ? sp[k] : ((k == 7 && absf) ? baro : 16'h0000);
    e_nen = (k < 3) || (k == 7);
    e_ren = (k >= 3) && (k < 6);
  endfunction : expect_cmd
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (awvalid || wvalid);
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", bresp, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", rdata, e);
    chk("rresp", rresp, r);
  endtask : rd
  task automatic line(input string a, input int k);
    int base;
    bit hit;
    base = host_u.n_prompt;
    hit = (a == "" && own == 8'h31) || (a.len() == 1 && 8'(a[0]) == own);
    host_u.send({a, codes[k]});
    if (hit) expect_cmd(k);
    n_exp += hit;
    for (int i = 0; i < 40 && host_u.n_prompt == base; i++) @(posedge clk);
    @(posedge clk);
    chk("prompts", host_u.n_prompt, n_exp);
    if (hit) chk("prompt", host_u.last_prompt, pch);
    chk("valves", sol, e_sol);
    chk("target", tgt, e_tgt);
    chk("enables", {nen, ren}, {e_nen, e_ren});
  endtask : line
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h00, 32'h0000313E, 2'h0);
    rd(8'hFC, 32'h0, 2'h2);
    for (int i = 0; i < 8; i++)
    begin
      mp[i] = 12'(rnd());
      sp[i % 6] = (i < 6) ? 16'(rnd()) : sp[i % 6];
      wr(8'h40 + 8'(4 * i), {20'h0, mp[i]}, 2'h0);
      if (i < 6) wr(8'h10 + 8'(4 * i), {16'h0, sp[i]}, 2'h0);
    end
    wr(8'h08, 32'h1, 2'h2);
    rd(8'h10, {16'h0000, sp[0]}, 2'h0);
    rd(8'h5C, {20'h00000, mp[7]}, 2'h0);
    $display("test registers done");
    for (int k = 0; k < 8; k++) line("", k);
    line("1U", 0);
    $display("test codes done");
    for (int i = 0; i < 24; i++)
    begin
      slow <= 1'(rnd());
      line(addrs[int'(rnd() % 5)], int'(rnd() % 8));
    end
    $display("test random done");
    baro = 16'(rnd());
    wr(8'h04, {16'h0, baro}, 2'h0);
    rd(8'h04, {16'h0000, baro}, 2'h0);
    own = 8'h55;
    pch = 8'h3C;
    absf = 1'b1;
    wr(8'h00, 32'h0001553C, 2'h0);
    line("U", 7);
    line("", 0);
    line("1", 1);
    line("U", 6);
    line("U", 4);
    rd(8'h08, {13'h0000, 3'h2, sp[4]}, 2'h0);
    $display("test config done");
    finish_test();
  end
  initial
  begin
    #2000000;
    err_total++;
    finish_test();
  end
endmodule : testbench
`default_nettype wire
